// >>> hw/gpio_exp_pkg.sv
// shared constants and types of the serial gpio expander
package gpio_exp_pkg;
  localparam int PORT_W    = 8;
  localparam int NUM_PORTS = 2;
  localparam int GPIO_W    = 16;
  localparam int AXI_AW    = 8;

  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_IN0    = 4'h0;
  localparam logic [3:0] IDX_IN1    = 4'h1;
  localparam logic [3:0] IDX_OUT0   = 4'h2;
  localparam logic [3:0] IDX_OUT1   = 4'h3;
  localparam logic [3:0] IDX_POL0   = 4'h4;
  localparam logic [3:0] IDX_POL1   = 4'h5;
  localparam logic [3:0] IDX_CFG0   = 4'h6;
  localparam logic [3:0] IDX_CFG1   = 4'h7;
  localparam logic [3:0] IDX_STATUS = 4'h8;

  // register group taken from index bits 2:1
  localparam logic [1:0] GRP_IN  = 2'h0;
  localparam logic [1:0] GRP_OUT = 2'h1;
  localparam logic [1:0] GRP_POL = 2'h2;
  localparam logic [1:0] GRP_CFG = 2'h3;

  localparam logic [7:0] OUT_RST = 8'hFF;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hFF;

  // upper five bits of the serial target address, value is arbitrary
  localparam logic [4:0] DEV_ADDR_BASE = 5'h0B;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    L_IDLE, L_ADDR, L_ADDR_ACK, L_CMD, L_CMD_ACK, L_WR, L_WR_ACK, L_RD, L_RD_ACK
  } link_state_t;

  typedef struct packed {
    logic       wr;
    logic [2:0] cmd;
    logic [7:0] data;
  } xfer_req_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } bus_event_t;

  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_vec_t;
endpackage : gpio_exp_pkg

// >>> hw/sync_2ff.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module sync_2ff
  import gpio_exp_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t next_r;

  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  assign q = r.s2;
endmodule : sync_2ff

// >>> hw/bus_cond.sv
// edge, start and stop detection on synchronised scl and sda
`timescale 1ns/10ps
module bus_cond
  import gpio_exp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  input  wire logic scl,
  input  wire logic sda,
  output bus_event_t ev
);
  typedef struct packed {
    logic scl_q;
    logic sda_q;
  } cond_t;

  cond_t r;
  cond_t next_r;

  always_comb
  begin
    next_r.scl_q = scl;
    next_r.sda_q = sda;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '1;
    end
    else if (en)
    begin
      r <= next_r;
    end
  end

  // start: sda falls while scl high, stop: sda rises while scl high
  assign ev.rise  = scl & ~r.scl_q;
  assign ev.fall  = ~scl & r.scl_q;
  assign ev.start = scl & r.scl_q & r.sda_q & ~sda;
  assign ev.stop  = scl & r.scl_q & ~r.sda_q & sda;
endmodule : bus_cond

// >>> hw/gpio_expander.sv
// sixteen line gpio expander with serial target link and axi4-lite registers
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module gpio_expander
  import gpio_exp_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              reset_pin_n,
  input  wire logic              serial_clk,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic              addr_strap_low,
  input  wire logic              addr_strap_high,
  input  wire logic [GPIO_W-1:0] gpio_i,
  output logic      [GPIO_W-1:0] gpio_o,
  output logic      [GPIO_W-1:0] gpio_oe,
  output logic                   int_n_o,
  output logic                   int_n_oe,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  typedef struct packed {
    port_vec_t   outp;
    port_vec_t   pol;
    port_vec_t   cfg;
    port_vec_t   cap;
    logic        init;
    logic        alert;
    logic        lrun;
    logic        req_seen;
    logic [7:0]  xrdata;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  widx;
    logic        aw_ok;
    logic [7:0]  wdat;
    logic        wen;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } core_t;

  typedef struct packed {
    link_state_t st;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic        rw;
    logic        nack;
    logic [2:0]  ptr;
    logic        drv;
    logic        req_tog;
    xfer_req_t   req;
  } link_t;

  core_t      c;
  core_t      next_c;
  link_t      l;
  link_t      next_l;
  logic [17:0] csync;
  logic [5:0]  lsync;
  port_vec_t   live;
  logic        pin_ok;
  logic        req_s;
  logic        link_fire;
  logic        axi_wr_fire;
  logic        scl_s;
  logic        sda_s;
  logic        ce_s;
  logic        lrst_n;
  logic [6:0]  dev_addr;
  bus_event_t  ev;

  function automatic logic addr_ok(logic [AXI_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a[AXI_AW-1:6] == '0) && (a[5:2] <= IDX_STATUS);
  endfunction : addr_ok

  function automatic core_t reg_write(core_t s, logic [3:0] idx, logic [7:0] d);
    case (idx[2:1])
      GRP_OUT: s.outp[idx[0]] = d;
      GRP_POL: s.pol[idx[0]]  = d;
      GRP_CFG: s.cfg[idx[0]]  = d;
      default: ;
    endcase
    return s;
  endfunction : reg_write

  function automatic logic [7:0] reg_read(core_t s, port_vec_t pins, logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_STATUS)
    begin
      v = {6'h00, s.init, s.alert};
    end
    else
    begin
      case (idx[2:1])
        GRP_IN:  v = pins[idx[0]] ^ s.pol[idx[0]];
        GRP_OUT: v = s.outp[idx[0]];
        GRP_POL: v = s.pol[idx[0]];
        default: v = s.cfg[idx[0]];
      endcase
    end
    return v;
  endfunction : reg_read

  // reading an input register takes the pin levels as the new reference
  function automatic core_t capture(core_t s, port_vec_t pins, logic [3:0] idx);
    if (idx[3:1] == 3'h0)
    begin
      s.cap[idx[0]] = pins[idx[0]];
    end
    return s;
  endfunction : capture

  function automatic logic [2:0] pair_next(logic [2:0] p);
    return {p[2:1], ~p[0]};
  endfunction : pair_next

  sync_2ff #(.W(18)) u_core_sync (
    .clk (aclk),
    .d   ({reset_pin_n, l.req_tog, gpio_i}),
    .q   (csync)
  );

  assign pin_ok    = csync[17];
  assign req_s     = csync[16];
  assign live      = csync[15:0];
  assign link_fire = (req_s != c.req_seen);

  always_comb
  begin
    next_c = c;
    if (!c.init)
    begin
      next_c.cap  = live;
      next_c.init = 1'b1;
    end
    next_c.lrun = 1'b1;
    // request from the serial link, payload held stable by the toggle handshake
    if (link_fire)
    begin
      next_c.req_seen = req_s;
      if (l.req.wr)
      begin
        next_c = reg_write(next_c, {1'b0, l.req.cmd}, l.req.data);
      end
      else
      begin
        next_c.xrdata = reg_read(c, live, {1'b0, l.req.cmd});
        next_c        = capture(next_c, live, {1'b0, l.req.cmd});
      end
    end
    if (awvalid && awready)
    begin
      next_c.aw_got = 1'b1;
      next_c.widx   = awaddr[5:2];
      next_c.aw_ok  = addr_ok(awaddr);
    end
    if (wvalid && wready)
    begin
      next_c.w_got = 1'b1;
      next_c.wdat  = wdata[7:0];
      next_c.wen   = wstrb[0];
    end
    if (c.aw_got && c.w_got && !c.bvalid)
    begin
      next_c.aw_got = 1'b0;
      next_c.w_got  = 1'b0;
      next_c.bvalid = 1'b1;
      next_c.bresp  = c.aw_ok ? RESP_OKAY : RESP_SLVERR;
      if (c.aw_ok && c.wen && !c.widx[3])
      begin
        next_c = reg_write(next_c, c.widx, c.wdat);
      end
    end
    if (c.bvalid && bready)
    begin
      next_c.bvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_c.rvalid = 1'b1;
      next_c.rresp  = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      next_c.rdata  = addr_ok(araddr) ? {24'h000000, reg_read(c, live, araddr[5:2])} : 32'h00000000;
      if (addr_ok(araddr))
      begin
        next_c = capture(next_c, live, araddr[5:2]);
      end
    end
    if (c.rvalid && rready)
    begin
      next_c.rvalid = 1'b0;
    end
    next_c.alert = c.init && (live != next_c.cap);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !pin_ok)
    begin
      c          <= '0;
      c.outp     <= {OUT_RST, OUT_RST};
      c.pol      <= {POL_RST, POL_RST};
      c.cfg      <= {CFG_RST, CFG_RST};
      c.req_seen <= req_s;
    end
    else if (ce)
    begin
      c <= next_c;
    end
  end

  // handshakes stall while ce freezes the core, so no beat is taken and then lost
  assign awready  = ce && !c.aw_got && !c.bvalid;
  assign wready   = ce && !c.w_got && !c.bvalid;
  assign arready  = ce && !c.rvalid;
  assign bvalid   = ce && c.bvalid;
  assign bresp    = c.bresp;
  assign rvalid   = ce && c.rvalid;
  assign rresp    = c.rresp;
  assign rdata    = c.rdata;
  // bit m of port n drives pin m of that port, both levels when output
  assign gpio_o   = c.outp;
  assign gpio_oe  = ~c.cfg;
  assign int_n_o  = 1'b0;
  assign int_n_oe = c.alert;

  // link side, oversampled well above the fast-mode serial clock
  sync_2ff #(.W(6)) u_link_sync (
    .clk (serial_clk),
    .d   ({scl_i, sda_i, addr_strap_high, addr_strap_low, ce, c.lrun}),
    .q   (lsync)
  );

  assign scl_s    = lsync[5];
  assign sda_s    = lsync[4];
  assign ce_s     = lsync[1];
  assign lrst_n   = lsync[0];
  assign dev_addr = {DEV_ADDR_BASE, lsync[3], lsync[2]};

  bus_cond u_bus_cond (
    .clk   (serial_clk),
    .rst_n (lrst_n),
    .en    (ce_s),
    .scl   (scl_s),
    .sda   (sda_s),
    .ev    (ev)
  );

  always_comb
  begin
    logic       issue;
    logic       iss_wr;
    logic [2:0] iss_cmd;
    issue   = 1'b0;
    iss_wr  = 1'b0;
    iss_cmd = l.ptr;
    next_l  = l;
    if (ev.stop)
    begin
      next_l.st  = L_IDLE;
      next_l.drv = 1'b0;
    end
    else if (ev.start)
    begin
      next_l.st   = L_ADDR;
      next_l.bitc = 4'h0;
      next_l.drv  = 1'b0;
    end
    else if (ev.rise)
    begin
      if (l.bitc < BYTE_BITS)
      begin
        next_l.bitc = l.bitc + 4'h1;
        if (l.st != L_RD)
        begin
          next_l.sh = {l.sh[6:0], sda_s};
        end
      end
      if (l.st == L_RD_ACK)
      begin
        next_l.nack = sda_s;
      end
    end
    else if (ev.fall)
    begin
      case (l.st)
        L_ADDR:
        begin
          if (l.bitc == BYTE_BITS)
          begin
            if (l.sh[7:1] == dev_addr)
            begin
              next_l.drv = 1'b1;
              next_l.rw  = l.sh[0];
              next_l.st  = L_ADDR_ACK;
              issue      = l.sh[0];
            end
            else
            begin
              next_l.st = L_IDLE;
            end
          end
        end
        L_ADDR_ACK, L_RD_ACK:
        begin
          next_l.bitc = 4'h0;
          if ((l.st == L_ADDR_ACK && !l.rw) || (l.st == L_RD_ACK && l.nack))
          begin
            next_l.drv = 1'b0;
            next_l.st  = (l.st == L_RD_ACK) ? L_IDLE : L_CMD;
          end
          else
          begin
            next_l.sh  = c.xrdata;
            next_l.drv = ~c.xrdata[7];
            next_l.st  = L_RD;
          end
        end
        L_CMD:
        begin
          if (l.bitc == BYTE_BITS)
          begin
            next_l.ptr = l.sh[2:0];
            next_l.drv = 1'b1;
            next_l.st  = L_CMD_ACK;
          end
        end
        L_CMD_ACK:
        begin
          next_l.drv  = 1'b0;
          next_l.bitc = 4'h0;
          next_l.st   = L_WR;
        end
        L_WR:
        begin
          if (l.bitc == BYTE_BITS)
          begin
            next_l.drv = 1'b1;
            next_l.st  = L_WR_ACK;
            issue      = 1'b1;
            iss_wr     = 1'b1;
          end
        end
        L_WR_ACK:
        begin
          next_l.drv  = 1'b0;
          next_l.bitc = 4'h0;
          next_l.ptr  = pair_next(l.ptr);
          next_l.st   = L_WR;
        end
        L_RD:
        begin
          if (l.bitc == BYTE_BITS)
          begin
            next_l.drv = 1'b0;
            next_l.ptr = pair_next(l.ptr);
            next_l.st  = L_RD_ACK;
            issue      = 1'b1;
            iss_cmd    = pair_next(l.ptr);
          end
          else
          begin
            next_l.sh  = {l.sh[6:0], 1'b0};
            next_l.drv = ~l.sh[6];
          end
        end
        default: ;
      endcase
    end
    if (issue)
    begin
      next_l.req_tog  = ~l.req_tog;
      next_l.req.wr   = iss_wr;
      next_l.req.cmd  = iss_cmd;
      next_l.req.data = l.sh;
    end
  end

  always_ff @(posedge serial_clk)
  begin
    if (!lrst_n)
    begin
      l         <= '0;
      l.st      <= L_IDLE;
      l.req_tog <= l.req_tog;
    end
    else if (ce_s)
    begin
      l <= next_l;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = l.drv;

  assign axi_wr_fire = c.aw_got && c.w_got && !c.bvalid && c.aw_ok && c.wen && ce && pin_ok && !link_fire;

  property p_reset_defaults;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (gpio_oe == ~{CFG_RST, CFG_RST}) && (gpio_o == {OUT_RST, OUT_RST}) && !int_n_oe;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults wrong after reset");

  property p_pin_reset;
    @(posedge aclk) disable iff (!aresetn)
    !pin_ok |=> (gpio_oe == ~{CFG_RST, CFG_RST}) && (gpio_o == {OUT_RST, OUT_RST});
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not hold defaults");

  property p_dir_write;
    @(posedge aclk) disable iff (!aresetn)
    (axi_wr_fire && c.widx == IDX_CFG0) |=> (gpio_oe[7:0] == ~$past(c.wdat)) && $stable(gpio_oe[15:8]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write wrong");

  property p_out_write;
    @(posedge aclk) disable iff (!aresetn)
    (axi_wr_fire && c.widx == IDX_OUT1) |=> (gpio_o[15:8] == $past(c.wdat)) && $stable(gpio_o[7:0]);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output write wrong");

  property p_in_ignore;
    @(posedge aclk) disable iff (!aresetn)
    (axi_wr_fire && c.widx[3:1] == 3'h0) |=> $stable(gpio_o) && $stable(gpio_oe);
  endproperty
  a_in_ignore: assert property (p_in_ignore) else $error("input register write took effect");

  property p_pol_read;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && ce && pin_ok && araddr == {2'h0, IDX_IN0, 2'h0})
      |=> rvalid && (rdata[7:0] == ($past(live[0]) ^ $past(c.pol[0])));
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("input read ignores inversion");

  property p_alert_set;
    @(posedge aclk) disable iff (!aresetn)
    (c.init && live != c.cap && ce && pin_ok && !link_fire && !(arvalid && arready)) |=> int_n_oe;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert missing on change");

  property p_alert_clear;
    @(posedge aclk) disable iff (!aresetn)
    (c.init && live == c.cap && ce && pin_ok) |=> !int_n_oe;
  endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("alert not released");

  property p_addr_ack;
    @(posedge serial_clk) disable iff (!lrst_n)
    (ce_s && ev.fall && !ev.start && !ev.stop && l.st == L_ADDR && l.bitc == BYTE_BITS && l.sh[7:1] == dev_addr)
      |=> sda_oe [*2];
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
endmodule : gpio_expander

// >>> test/serial_master.sv
// serial two-wire bus master model, the far side of the link
`timescale 1ns/10ps
module serial_master
(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  localparam time Q = 625ns; // 2.5 us bit period, never faster than fast mode

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic put_bit(input logic b);
    sda_low = ~b;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda_line;
    #Q scl = 1'b0;
    #Q;
  endtask : get_bit

  task automatic start_cond;
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start_cond

  task automatic stop_cond;
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic nack;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(nack);
    ack = ~nack;
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] d, input logic last);
    logic bt;
    for (int i = 7; i >= 0; i--)
    begin
      get_bit(bt);
      d[i] = bt;
    end
    put_bit(last);
  endtask : recv_byte
endmodule : serial_master

// >>> test/testbench.sv
// self-checking bench of the gpio expander: registers, serial link and pins
`timescale 1ns/10ps
module testbench
  import gpio_exp_pkg::*;
;
  logic              aclk = 1'b0, serial_clk = 1'b0, aresetn = 1'b0, reset_pin_n = 1'b1, ce_in = 1'b1;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [AXI_AW-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]       wdata = 32'h0, rdata, seed = 32'h00000020;
  logic [3:0]        wstrb = 4'h0;
  logic [1:0]        bresp, rresp, straps = 2'h2;
  logic              awready, wready, bvalid, arready, rvalid, sda_oe, sda_o, int_n_o, int_n_oe;
  logic              scl, m_sda_low, sda_line, ack;
  logic [7:0]        sd;
  logic [GPIO_W-1:0] ext_pins = 16'h0000, gpio_i, gpio_o, gpio_oe;
  port_vec_t         out_v, pol_v, dir_v;
  int                err_total = 0, samples_checked = 0, it, p;

  assign sda_line = ~(m_sda_low | sda_oe);
  assign gpio_i   = (gpio_oe & gpio_o) | (~gpio_oe & ext_pins);

  gpio_expander i_gpio_expander (.aclk(aclk), .aresetn(aresetn), .ce(ce_in), .reset_pin_n(reset_pin_n),
    .serial_clk(serial_clk), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_low(straps[0]), .addr_strap_high(straps[1]), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  serial_master i_serial_master (.scl(scl), .sda_low(m_sda_low), .sda_line(sda_line));

  initial
  begin
    forever #2 aclk = ~aclk;
  end

  initial
  begin
    #3.3;
    forever #7.5 serial_clk = ~serial_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [AXI_AW-1:0] ba(input logic [3:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : ba

  function automatic logic [31:0] exp_in(input int n);
    logic [15:0] pin;
    pin = (~dir_v & out_v) | (dir_v & ext_pins);
    return {24'h0, pin[8*n +: 8] ^ pol_v[n]};
  endfunction : exp_in

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one access; a read compares its data with d
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic        a_hs, w_hs, done;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          n;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= wr;
    wvalid  <= wr;
    bready  <= wr;
    arvalid <= !wr;
    rready  <= !wr;
    for (n = 0; n < 50 && !done; n++)
    begin
      @(negedge aclk);
      a_hs = (awvalid && awready) || (arvalid && arready);
      w_hs = wvalid && wready;
      done = (bvalid && bready) || (rvalid && rready);
      rd   = rdata;
      rs   = wr ? bresp : rresp;
      @(posedge aclk);
      awvalid <= awvalid && !a_hs;
      arvalid <= arvalid && !a_hs;
      wvalid  <= wvalid && !w_hs;
      bready  <= bready && !done;
      rready  <= rready && !done;
    end
    chk({31'h0, done}, 32'h1);
    chk({30'h0, rs}, {30'h0, er});
    if (!wr)
      chk(rd, d);
  endtask : acc

  task automatic pin_step(input logic [15:0] v, input logic e);
    @(posedge aclk);
    ext_pins <= v;
    repeat (6) @(negedge aclk);
    chk({31'h0, int_n_oe}, {31'h0, e});
  endtask : pin_step

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    #380us;
    chk(32'h0, 32'h1);
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    chk({16'h0, gpio_oe}, 32'h0);
    chk({16'h0, gpio_o}, 32'h0000FFFF);
    chk({31'h0, int_n_oe}, 32'h0);
    chk({30'h0, int_n_o, sda_o}, 32'h0);
    for (p = 2; p < 8; p++)
      acc(1'b0, ba(4'(p)), (p / 2 == 2) ? 32'h0 : 32'hFF, RESP_OKAY);
    acc(1'b0, 8'h24, 32'h0, RESP_SLVERR);
    acc(1'b1, 8'h24, 32'h1, RESP_SLVERR);
    acc(1'b0, 8'h02, 32'h0, RESP_SLVERR);
    for (it = 0; it < 10; it++)
    begin
      out_v = (it == 0) ? 16'h0000 : 16'(xs());
      pol_v = (it == 0) ? 16'hFFFF : 16'(xs());
      dir_v = (it == 0) ? 16'h7FFE : 16'(xs());
      for (p = 0; p < 2; p++)
      begin
        acc(1'b1, ba(IDX_OUT0 + 4'(p)), {24'h0, out_v[p]}, RESP_OKAY);
        acc(1'b1, ba(IDX_POL0 + 4'(p)), {24'h0, pol_v[p]}, RESP_OKAY);
        acc(1'b1, ba(IDX_CFG0 + 4'(p)), {24'h0, dir_v[p]}, RESP_OKAY);
        acc(1'b1, ba(IDX_IN0 + 4'(p)), xs(), RESP_OKAY);
      end
      ext_pins <= 16'(xs());
      repeat (4) @(negedge aclk);
      chk({16'h0, gpio_oe}, {16'h0, ~dir_v});
      chk({16'h0, gpio_o}, {16'h0, out_v});
      for (p = 0; p < 2; p++)
      begin
        acc(1'b0, ba(IDX_IN0 + 4'(p)), exp_in(p), RESP_OKAY);
        acc(1'b0, ba(IDX_OUT0 + 4'(p)), {24'h0, out_v[p]}, RESP_OKAY);
        acc(1'b0, ba(IDX_POL0 + 4'(p)), {24'h0, pol_v[p]}, RESP_OKAY);
        acc(1'b0, ba(IDX_CFG0 + 4'(p)), {24'h0, dir_v[p]}, RESP_OKAY);
      end
    end
    dir_v = 16'hFFFF;
    for (p = 0; p < 2; p++)
      acc(1'b1, ba(IDX_CFG0 + 4'(p)), 32'hFF, RESP_OKAY);
    pin_step(16'h0000, 1'b1);
    for (p = 0; p < 2; p++)
      acc(1'b0, ba(IDX_IN0 + 4'(p)), exp_in(p), RESP_OKAY);
    repeat (4) @(negedge aclk);
    chk({31'h0, int_n_oe}, 32'h0);
    pin_step(16'h0200, 1'b1);
    acc(1'b0, ba(IDX_STATUS), 32'h3, RESP_OKAY);
    pin_step(16'h0000, 1'b0);
    @(posedge aclk);
    ce_in <= 1'b0;
    pin_step(16'h0008, 1'b0);
    @(posedge aclk);
    ce_in <= 1'b1;
    pin_step(16'h0008, 1'b1);
    acc(1'b0, ba(IDX_IN0), exp_in(0), RESP_OKAY);
    repeat (4) @(negedge aclk);
    chk({31'h0, int_n_oe}, 32'h0);
    acc(1'b1, ba(IDX_OUT0), 32'h5A, RESP_OKAY);
    acc(1'b1, ba(IDX_CFG0), 32'h00, RESP_OKAY);
    reset_pin_n <= 1'b0;
    repeat (8) @(negedge aclk);
    chk({16'h0, gpio_oe}, 32'h0);
    chk({16'h0, gpio_o}, 32'h0000FFFF);
    @(posedge aclk);
    reset_pin_n <= 1'b1;
    repeat (8) @(negedge aclk);
    acc(1'b0, ba(IDX_CFG0), 32'hFF, RESP_OKAY);
    acc(1'b0, ba(IDX_OUT0), 32'hFF, RESP_OKAY);
    repeat (50) @(posedge aclk);
    i_serial_master.start_cond();
    i_serial_master.send_byte({DEV_ADDR_BASE, straps, 1'b0}, ack);
    chk({31'h0, ack}, 32'h1);
    for (p = 0; p < 3; p++)
    begin
      i_serial_master.send_byte((p == 0) ? 8'h02 : ((p == 1) ? 8'hA5 : 8'h3C), ack);
      chk({31'h0, ack}, 32'h1);
    end
    i_serial_master.stop_cond();
    acc(1'b0, ba(IDX_OUT0), 32'hA5, RESP_OKAY);
    acc(1'b0, ba(IDX_OUT1), 32'h3C, RESP_OKAY);
    i_serial_master.start_cond();
    i_serial_master.send_byte({DEV_ADDR_BASE, straps, 1'b0}, ack);
    i_serial_master.send_byte(8'h02, ack);
    i_serial_master.start_cond();
    i_serial_master.send_byte({DEV_ADDR_BASE, straps, 1'b1}, ack);
    chk({31'h0, ack}, 32'h1);
    i_serial_master.recv_byte(sd, 1'b0);
    chk({24'h0, sd}, 32'hA5);
    i_serial_master.recv_byte(sd, 1'b1);
    chk({24'h0, sd}, 32'h3C);
    i_serial_master.stop_cond();
    i_serial_master.start_cond();
    i_serial_master.send_byte({DEV_ADDR_BASE, ~straps, 1'b0}, ack);
    chk({31'h0, ack}, 32'h0);
    i_serial_master.stop_cond();
    end_sim();
  end
endmodule : testbench
